/* logic/config_status_bank.sv */
// Notes on behaviour
// R1: Open-load mask keeps open-load out of global
// R2: Serial mask keeps serial errors out of global
// R3: Physical mask keeps phy errors out of global
// R4: Warning mask keeps warnings out of global
// R5: Locked pump disable accepts only clearing writes
// R6: Unlock clears after following command completes
// R7: Pump-low latched or live per config bit
// R8: Dither pump clock unless dither disable set
// R9: Force bit drives fail-safe outputs, no reset
// R10: Aux supply feeds transceiver, ignores field 11
// R11: Wake level bit live in wake-input use, immune to clears
// R12: Wake level frozen outside wake-input use
// R13: Wake sources latch until read-and-clear
// R14: Wake function 0 wake input, 1 measurement
// R15: Pump disable set only while unlocked
// R16: Global error ORs unmasked classes only
// R17: Config 2:1 and status 23,21 read zero
module config_status_bank
	import bank_pkg::*;
(
	// Clock and reset
	input wire logic MCLK,
	input wire logic SRST,
	// Decoded serial command port
	input wire logic CMD_VALID,
	input wire logic [1:0] CMD_OP,
	input wire logic [5:0] CMD_ADDR,
	input wire logic [23:0] CMD_WDATA,
	output logic [23:0] RDATA,
	output logic RDATA_VALID,
	// Error classes
	input wire logic ERR_OPEN_LOAD,
	input wire logic ERR_SERIAL,
	input wire logic ERR_PHY,
	input wire logic WARN_COND,
	input wire logic ERR_OTHER,
	output logic [7:0] SUMMARY_STATUS,
	// Charge pump
	input wire logic PUMP_LOW_COND,
	input wire logic PUMP_LOW_CLEAR,
	output logic PUMP_LOW_FLAG,
	output logic PUMP_OUTPUTS_OFF,
	output logic PUMP_DISABLE,
	output logic PUMP_DITHER_EN,
	// Fail-safe
	input wire logic FS_LOGIC_ON,
	output logic FAILSAFE_LOW_SIDE_ON,
	output logic FAILSAFE_MODE,
	// Transceiver supply
	input wire logic [1:0] SUPPLY_FIELD_IN,
	output logic [1:0] SUPPLY_FIELD_EFF,
	output logic TRANSCEIVER_SUPPLY_AUX,
	// Watchdog
	output logic WATCHDOG_KICK,
	// Wake
	input wire logic WAKE_PIN,
	input wire logic WAKE_EV_PIN,
	input wire logic WAKE_EV_CAN,
	input wire logic WAKE_EV_LIN,
	input wire logic WAKE_EV_TIMER,
	output logic WAKE_MEASURE_MODE
);
	wake_if wk ();

	logic [23:0] cfg_q, cfg_d;
	logic pump_dis_q, pump_dis_d;
	logic [23:0] rdata_q, rdata_d;
	logic rvalid_q, rvalid_d;
	logic kick_q, kick_d;
	logic [7:0] sum_q, sum_d;
	logic plow_q, plow_d;
	logic poff_q, poff_d;
	logic fs_on_q, fs_on_d;
	logic fs_mode_q, fs_mode_d;
	logic [1:0] field_q, field_d;
	logic aux_q, aux_d;
	logic dith_q, dith_d;
	logic meas_q, meas_d;
	logic pin_meta_q, pin_sync_q;
	logic is_rc, is_read;
	logic wr_cfg, wr_pump, rc_status;

	// Matches one command against an op and a register address
	function automatic logic cmd_hit(input logic valid, input logic [1:0] op,
		input logic [5:0] addr, input logic [1:0] want_op, input logic [5:0] want_addr);
		return valid && (op == want_op) && (addr == want_addr);
	endfunction

	// Fail-safe drive: either the force bit or the fail-safe logic
	function automatic logic fs_drive(input logic force_on, input logic logic_on);
		return force_on | logic_on;
	endfunction

	// Command decode
	always_comb begin
		is_read = CMD_VALID && (CMD_OP == OP_READ);
		is_rc = CMD_VALID && (CMD_OP == OP_READ_CLEAR);
		wr_cfg = cmd_hit(CMD_VALID, CMD_OP, CMD_ADDR, OP_WRITE, CONFIG_ADDR);
		wr_pump = cmd_hit(CMD_VALID, CMD_OP, CMD_ADDR, OP_WRITE, PUMP_CTRL_ADDR);
		rc_status = cmd_hit(CMD_VALID, CMD_OP, CMD_ADDR, OP_READ_CLEAR, STATUS_ONE_ADDR);
	end

	// Configuration store and one-shot pump unlock
	always_comb begin
		cfg_d = cfg_q;
		kick_d = 1'b0;
		// Any command consumes an armed unlock once it completes
		if (CMD_VALID && cfg_q[CFG_PUMP_UNLOCK])
			cfg_d[CFG_PUMP_UNLOCK] = 1'b0; // R6
		if (wr_cfg) begin
			cfg_d = CMD_WDATA & CFG_WRITE_MASK; // R17
			// A fresh config write re-arms (or drops) the unlock itself
			kick_d = CMD_WDATA[CFG_KICK];
		end
	end

	// Pump disable write filter
	always_comb begin
		pump_dis_d = pump_dis_q;
		if (wr_pump) begin
			if (!CMD_WDATA[PUMP_DISABLE_BIT])
				pump_dis_d = 1'b0; // R5
			else if (cfg_q[CFG_PUMP_UNLOCK])
				pump_dis_d = 1'b1; // R15
		end
	end

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			cfg_q <= CFG_RESET;
			kick_q <= 1'b0;
			pump_dis_q <= 1'b0;
		end else begin
			cfg_q <= cfg_d;
			kick_q <= kick_d;
			pump_dis_q <= pump_dis_d;
		end
	end

	// Read data path, one cycle after the command
	always_comb begin
		rdata_d = rdata_q;
		rvalid_d = 1'b0;
		if (is_read || is_rc) begin
			rvalid_d = 1'b1;
			case (CMD_ADDR)
				CONFIG_ADDR: rdata_d = cfg_q;
				STATUS_ONE_ADDR: rdata_d = wk.status;
				PUMP_CTRL_ADDR: begin
					rdata_d = 24'h000000;
					rdata_d[PUMP_DISABLE_BIT] = pump_dis_q;
				end
				default: rdata_d = 24'h000000;
			endcase
		end
	end

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			rdata_q <= 24'h000000;
			rvalid_q <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	// Summary byte; a masked class still shows in its own bit
	always_comb begin
		sum_d = 8'h00;
		sum_d[SUM_FUNC_ERR] = ERR_OPEN_LOAD;
		sum_d[SUM_SERIAL_ERR] = ERR_SERIAL;
		sum_d[SUM_PHY_ERR] = ERR_PHY;
		sum_d[SUM_WARNING] = WARN_COND;
		sum_d[SUM_GLOBAL_ERR] = ERR_OTHER // R16
			| (ERR_OPEN_LOAD & ~cfg_q[CFG_MASK_OPEN_LOAD]) // R1
			| (ERR_SERIAL & ~cfg_q[CFG_MASK_SERIAL]) // R2
			| (ERR_PHY & ~cfg_q[CFG_MASK_PHY]) // R3
			| (WARN_COND & ~cfg_q[CFG_MASK_WARNING]); // R4
	end

	always_ff @(posedge MCLK) begin
		if (SRST)
			sum_q <= 8'h00;
		else
			sum_q <= sum_d;
	end

	// Pump-low flag: live copy, or a latch that only a clear empties
	always_comb begin
		if (cfg_q[CFG_PUMP_LOW_LIVE]) begin
			plow_d = PUMP_LOW_COND; // R7
		end else begin
			// Latched: a new low beats a clear in the same cycle
			plow_d = (plow_q & ~PUMP_LOW_CLEAR) | PUMP_LOW_COND; // R7
		end
		// Outputs stay off exactly as long as the flag stands
		poff_d = plow_d;
	end

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			plow_q <= 1'b0;
			poff_q <= 1'b0;
		end else begin
			plow_q <= plow_d;
			poff_q <= poff_d;
		end
	end

	// Dither enable is a registered copy of the inverted disable bit
	always_comb begin
		dith_d = ~cfg_q[CFG_DITHER_DIS]; // R8
	end

	always_ff @(posedge MCLK) begin
		if (SRST)
			dith_q <= 1'b1;
		else
			dith_q <= dith_d;
	end

	// Fail-safe override; forced mode never pulls the reset line, only the outputs
	always_comb begin
		fs_on_d = fs_drive(cfg_q[CFG_FS_FORCE], FS_LOGIC_ON); // R9
		// Mode and outputs share one cause so they cannot disagree
		fs_mode_d = fs_drive(cfg_q[CFG_FS_FORCE], FS_LOGIC_ON); // R9
	end

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			fs_on_q <= 1'b0;
			fs_mode_q <= 1'b0;
		end else begin
			fs_on_q <= fs_on_d;
			fs_mode_q <= fs_mode_d;
		end
	end

	// Transceiver supply steering
	always_comb begin
		aux_d = cfg_q[CFG_SUPPLY_AUX]; // R10
		field_d = SUPPLY_FIELD_IN;
		// Keep the last accepted field rather than applying 11; the hold
		// lasts only while the aux bit is set, the field is sampled live
		if (cfg_q[CFG_SUPPLY_AUX] && SUPPLY_FIELD_IN == SUPPLY_FIELD_BOTH)
			field_d = field_q; // R10
	end

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			aux_q <= 1'b0;
			field_q <= 2'h0;
		end else begin
			aux_q <= aux_d;
			field_q <= field_d;
		end
	end

	// Wake pin use, measurement by default
	always_comb begin
		meas_d = cfg_q[CFG_WAKE_FUNC]; // R14
	end

	always_ff @(posedge MCLK) begin
		if (SRST)
			meas_q <= 1'b1;
		else
			meas_q <= meas_d;
	end

	// Wake pin crosses in from outside through two stages
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			pin_meta_q <= 1'b0;
			pin_sync_q <= 1'b0;
		end else begin
			pin_meta_q <= WAKE_PIN;
			pin_sync_q <= pin_meta_q;
		end
	end

	// Wake status feed
	assign wk.level_track = ~cfg_q[CFG_WAKE_FUNC]; // R12 R14
	assign wk.pin_level = pin_sync_q;
	assign wk.events = {WAKE_EV_PIN, WAKE_EV_CAN, WAKE_EV_LIN, WAKE_EV_TIMER};
	assign wk.clear = rc_status; // R13

	wake_status u_wake (
		.clk(MCLK),
		.srst(SRST),
		.wk(wk)
	);

	// Output drive, all from flip-flops
	assign RDATA = rdata_q;
	assign RDATA_VALID = rvalid_q;
	assign SUMMARY_STATUS = sum_q;
	assign PUMP_LOW_FLAG = plow_q;
	assign PUMP_OUTPUTS_OFF = poff_q;
	assign PUMP_DISABLE = pump_dis_q;
	assign PUMP_DITHER_EN = dith_q;
	assign FAILSAFE_LOW_SIDE_ON = fs_on_q;
	assign FAILSAFE_MODE = fs_mode_q;
	assign SUPPLY_FIELD_EFF = field_q;
	assign TRANSCEIVER_SUPPLY_AUX = aux_q;
	assign WATCHDOG_KICK = kick_q;
	assign WAKE_MEASURE_MODE = meas_q;
endmodule

/* logic/bank_pkg.sv */
package bank_pkg;
	// Command codes on the decoded serial command port
	localparam logic [1:0] OP_READ = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ_CLEAR = 2'h2;

	// Register addresses
	localparam logic [5:0] STATUS_ONE_ADDR = 6'h31;
	localparam logic [5:0] CONFIG_ADDR = 6'h3F;
	localparam logic [5:0] PUMP_CTRL_ADDR = 6'h22;

	localparam int REG_W = 24;

	// Configuration field positions
	localparam int CFG_WAKE_FUNC = 23;
	localparam int CFG_MASK_OPEN_LOAD = 11;
	localparam int CFG_MASK_SERIAL = 10;
	localparam int CFG_MASK_PHY = 9;
	localparam int CFG_MASK_WARNING = 8;
	localparam int CFG_PUMP_UNLOCK = 7;
	localparam int CFG_PUMP_LOW_LIVE = 6;
	localparam int CFG_DITHER_DIS = 5;
	localparam int CFG_FS_FORCE = 4;
	localparam int CFG_SUPPLY_AUX = 3;
	localparam int CFG_KICK = 0;

	// Configuration reset value and writable bits (2:1 reserved)
	localparam logic [23:0] CFG_RESET = 24'h800001;
	localparam logic [23:0] CFG_WRITE_MASK = 24'hFFFFF9;

	// Pump control register field
	localparam int PUMP_DISABLE_BIT = 2;

	// Primary status field positions
	localparam int ST_WAKE_LEVEL = 22;
	localparam int ST_WAKE_PIN = 20;
	localparam int ST_WAKE_CAN = 19;
	localparam int ST_WAKE_LIN = 18;
	localparam int ST_WAKE_TIMER = 17;

	// Summary status byte positions
	localparam int SUM_GLOBAL_ERR = 7;
	localparam int SUM_SERIAL_ERR = 5;
	localparam int SUM_PHY_ERR = 4;
	localparam int SUM_FUNC_ERR = 3;
	localparam int SUM_WARNING = 1;

	// Supply field value that the aux supply overrides
	localparam logic [1:0] SUPPLY_FIELD_BOTH = 2'h3;
endpackage

/* logic/wake_if.sv */
interface wake_if;
	logic level_track;
	logic pin_level;
	logic [3:0] events;
	logic clear;
	logic [23:0] status;
	modport owner (output level_track, output pin_level, output events, output clear,
		input status);
	modport keeper (input level_track, input pin_level, input events, input clear,
		output status);
endinterface

/* logic/wake_status.sv */
module wake_status
	import bank_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	wake_if.keeper wk
);
	logic level_q, level_d;
	logic [3:0] src_q, src_d;

	// Level follows the pin only in wake-input use; clears never touch it
	always_comb begin
		level_d = wk.level_track ? wk.pin_level : level_q; // R11 R12
		// Set beats a clear in the same cycle
		src_d = (wk.clear ? 4'h0 : src_q) | wk.events; // R13
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			level_q <= 1'b0;
			src_q <= 4'h0;
		end else begin
			level_q <= level_d;
			src_q <= src_d;
		end
	end

	// Reserved bits 23 and 21 stay zero
	always_comb begin
		wk.status = 24'h000000; // R17
		wk.status[ST_WAKE_LEVEL] = level_q;
		wk.status[ST_WAKE_PIN] = src_q[3];
		wk.status[ST_WAKE_CAN] = src_q[2];
		wk.status[ST_WAKE_LIN] = src_q[1];
		wk.status[ST_WAKE_TIMER] = src_q[0];
	end
endmodule

/* bench/bank_props.sv */
module bank_props
	import bank_pkg::*;
(
	// Clock, reset, commands
	input wire logic MCLK,
	input wire logic SRST,
	input wire logic CMD_VALID,
	input wire logic [1:0] CMD_OP,
	input wire logic [5:0] CMD_ADDR,
	input wire logic [23:0] CMD_WDATA,
	// Error classes
	input wire logic ERR_OPEN_LOAD,
	input wire logic ERR_SERIAL,
	input wire logic ERR_PHY,
	input wire logic WARN_COND,
	input wire logic ERR_OTHER,
	input wire logic [7:0] SUMMARY_STATUS,
	// Pump, fail-safe, supply
	input wire logic PUMP_LOW_COND,
	input wire logic PUMP_LOW_FLAG,
	input wire logic PUMP_OUTPUTS_OFF,
	input wire logic PUMP_DISABLE,
	input wire logic FS_LOGIC_ON,
	input wire logic FAILSAFE_LOW_SIDE_ON,
	input wire logic [1:0] SUPPLY_FIELD_IN,
	input wire logic [1:0] SUPPLY_FIELD_EFF,
	input wire logic TRANSCEIVER_SUPPLY_AUX
);
	logic pw, unl_q;
	// Pump control write, unlock or not
	assign pw = CMD_VALID && CMD_OP == OP_WRITE && CMD_ADDR == PUMP_CTRL_ADDR;
	// Unlock as software sees it: armed by a config write, spent by the next command
	always_ff @(posedge MCLK) begin
		if (SRST)
			unl_q <= 1'b0;
		else if (CMD_VALID)
			unl_q <= CMD_OP == OP_WRITE && CMD_ADDR == CONFIG_ADDR && CMD_WDATA[CFG_PUMP_UNLOCK];
	end
	default clocking @(posedge MCLK); endclocking
	default disable iff (SRST);
	a_open_load_class: assert property ($past(ERR_OPEN_LOAD) |-> SUMMARY_STATUS[3])
		else $error("functional bit missing");
	a_serial_class: assert property ($past(ERR_SERIAL) |-> SUMMARY_STATUS[5])
		else $error("serial bit missing");
	a_phy_class: assert property ($past(ERR_PHY) |-> SUMMARY_STATUS[4])
		else $error("phy bit missing");
	a_warning_class: assert property ($past(WARN_COND) |-> SUMMARY_STATUS[1])
		else $error("warning bit missing");
	a_global_cause: assert property (SUMMARY_STATUS[7] |->
		$past(ERR_OPEN_LOAD || ERR_SERIAL || ERR_PHY || WARN_COND || ERR_OTHER))
		else $error("global bit without cause");
	a_pump_low_set: assert property ($past(PUMP_LOW_COND) |-> PUMP_LOW_FLAG && PUMP_OUTPUTS_OFF)
		else $error("pump low not flagged");
	a_pump_unlock_write: assert property ($rose(PUMP_DISABLE) |-> $past(pw && unl_q))
		else $error("pump disabled without write");
	a_failsafe_follow: assert property ($past(FS_LOGIC_ON) |-> FAILSAFE_LOW_SIDE_ON)
		else $error("fail-safe request lost");
	a_supply_hold: assert property (TRANSCEIVER_SUPPLY_AUX && $past(SUPPLY_FIELD_IN) == 2'h3
		|-> $stable(SUPPLY_FIELD_EFF))
		else $error("supply field 11 taken");
	// Main scenarios reached
	c_masked: cover property (SUMMARY_STATUS[1] && !SUMMARY_STATUS[7]);
	c_pump_off: cover property ($rose(PUMP_DISABLE));
	c_low_clear: cover property ($fell(PUMP_LOW_FLAG));
endmodule

bind config_status_bank bank_props chk_u (.*);

/* bench/mcu_model.sv */
module mcu_model
	import bank_pkg::*;
(
	input wire logic MCLK,
	input wire logic RDATA_VALID,
	input wire logic [23:0] RDATA,
	output logic CMD_VALID,
	output logic [1:0] CMD_OP,
	output logic [5:0] CMD_ADDR,
	output logic [23:0] CMD_WDATA
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		{CMD_VALID, CMD_OP, CMD_ADDR, CMD_WDATA} = 33'h0;
	end
	// One command, held across exactly one rising edge
	task automatic send(input logic [1:0] op, input logic [5:0] a, input logic [23:0] d,
		output logic [23:0] rd, output bit ok);
		@(negedge MCLK);
		{CMD_VALID, CMD_OP, CMD_ADDR, CMD_WDATA} = {1'b1, op, a, d};
		@(negedge MCLK);
		// Idle address and data lines show the inverse so stale data cannot pass
		{CMD_VALID, CMD_ADDR, CMD_WDATA} = {1'b0, ~a, ~d};
		ok = (op == OP_WRITE);
		rd = 24'h000000;
		for (int n = 0; n < 3 && !ok; n++) begin
			if (RDATA_VALID === 1'b1) begin
				rd = RDATA;
				ok = 1'b1;
			end else
				@(negedge MCLK);
		end
	endtask
endmodule

/* bench/error_mask_config_and_wake_status_bench.sv */
module error_mask_config_and_wake_status_bench import bank_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic MCLK = 1'b0, SRST = 1'b1, CMD_VALID, RDATA_VALID, PUMP_LOW_COND, PUMP_LOW_CLEAR;
	logic [1:0] CMD_OP, SUPPLY_FIELD_IN, SUPPLY_FIELD_EFF;
	logic [5:0] CMD_ADDR;
	logic [23:0] CMD_WDATA, RDATA, rd;
	logic [7:0] SUMMARY_STATUS;
	logic [4:0] err;
	logic [3:0] ev, m;
	logic ERR_OPEN_LOAD, ERR_SERIAL, ERR_PHY, WARN_COND, ERR_OTHER, PUMP_LOW_FLAG;
	logic PUMP_OUTPUTS_OFF, PUMP_DISABLE, PUMP_DITHER_EN, FS_LOGIC_ON, FAILSAFE_LOW_SIDE_ON;
	logic FAILSAFE_MODE, TRANSCEIVER_SUPPLY_AUX, WATCHDOG_KICK, WAKE_PIN, WAKE_MEASURE_MODE;
	logic WAKE_EV_PIN, WAKE_EV_CAN, WAKE_EV_LIN, WAKE_EV_TIMER;
	bit ok;
	int miscompares = 0, num_checks = 0;
	assign {ERR_OTHER, WARN_COND, ERR_PHY, ERR_SERIAL, ERR_OPEN_LOAD} = err;
	assign {WAKE_EV_PIN, WAKE_EV_CAN, WAKE_EV_LIN, WAKE_EV_TIMER} = ev;
	always #5 MCLK = ~MCLK;
	config_status_bank dut_u (.*);
	mcu_model mcu_u (.*);
	task stop_test;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input logic [23:0] g, e);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask
	// Bounded answer wait lives in the model
	task cmd(input logic [1:0] op, input logic [5:0] a, input logic [23:0] d);
		mcu_u.send(op, a, d, rd, ok);
		if (!ok) begin
			miscompares++;
			$display("[FAIL] %0t no read answer", $time);
			stop_test;
		end
	endtask
	task rdc(input logic [5:0] a, input logic [23:0] e);
		cmd(OP_READ, a, 24'h000000);
		chk(rd, e);
	endtask
	task wn(input int n);
		repeat (n) @(negedge MCLK);
	endtask
	// Expected summary byte: masks only keep classes out of the global bit
	function automatic logic [7:0] exp_sum(logic [4:0] e, logic [3:0] k);
		return {|(e[3:0] & ~k) | e[4], 1'b0, e[1], e[2], e[0], 1'b0, e[3], 1'b0};
	endfunction
	initial begin
		{err, ev, PUMP_LOW_COND, PUMP_LOW_CLEAR, FS_LOGIC_ON, WAKE_PIN} = 13'h0;
		SUPPLY_FIELD_IN = 2'h1;
		void'($urandom(3));
		wn(3);
		SRST = 1'b0;
		rdc(CONFIG_ADDR, CFG_RESET);
		chk(PUMP_DITHER_EN, 1);
		rdc(STATUS_ONE_ADDR, 24'h000000);
		rdc(6'h10, 24'h000000);
		cmd(OP_WRITE, CONFIG_ADDR, 24'hFFFF7F);
		// Kick is a one-cycle pulse after a config write with bit 0 set
		chk(WATCHDOG_KICK, 1);
		rdc(CONFIG_ADDR, 24'hFFFF79);
		chk(WATCHDOG_KICK, 0);
		chk(PUMP_DITHER_EN, 0);
		chk(FAILSAFE_LOW_SIDE_ON && FAILSAFE_MODE, 1);
		SUPPLY_FIELD_IN = 2'h3;
		wn(2);
		chk({TRANSCEIVER_SUPPLY_AUX, SUPPLY_FIELD_EFF}, 3'h5);
		// First pass is the all-masked corner
		for (int i = 0; i < 24; i++) begin
			m = (i == 0) ? 4'hF : 4'($urandom);
			cmd(OP_WRITE, CONFIG_ADDR, {12'h000, m[0], m[1], m[2], m[3], 8'h00});
			err = (i == 0) ? 5'h0F : 5'($urandom);
			{FS_LOGIC_ON, SUPPLY_FIELD_IN} = 3'($urandom);
			wn(2);
			chk(SUMMARY_STATUS, exp_sum(err, m));
		end
		err = 5'h00;
		cmd(OP_WRITE, PUMP_CTRL_ADDR, 24'h000004);
		wn(2);
		chk(PUMP_DISABLE, 0);
		cmd(OP_WRITE, CONFIG_ADDR, 24'h000080);
		cmd(OP_WRITE, PUMP_CTRL_ADDR, 24'h000004);
		wn(2);
		chk(PUMP_DISABLE, 1);
		cmd(OP_WRITE, PUMP_CTRL_ADDR, 24'h000000);
		wn(2);
		chk(PUMP_DISABLE, 0);
		cmd(OP_WRITE, CONFIG_ADDR, 24'h000080);
		rdc(STATUS_ONE_ADDR, 24'h000000);
		cmd(OP_WRITE, PUMP_CTRL_ADDR, 24'h000004);
		rdc(CONFIG_ADDR, 24'h000000);
		chk(PUMP_DISABLE, 0);
		PUMP_LOW_COND = 1'b1;
		wn(1);
		PUMP_LOW_COND = 1'b0;
		wn(3);
		chk(PUMP_LOW_FLAG, 1);
		PUMP_LOW_CLEAR = 1'b1;
		wn(1);
		PUMP_LOW_CLEAR = 1'b0;
		wn(2);
		chk(PUMP_LOW_FLAG, 0);
		cmd(OP_WRITE, CONFIG_ADDR, 24'h000040);
		PUMP_LOW_COND = 1'b1;
		wn(2);
		chk(PUMP_OUTPUTS_OFF, 1);
		PUMP_LOW_COND = 1'b0;
		wn(2);
		chk(PUMP_LOW_FLAG, 0);
		WAKE_PIN = 1'b1;
		wn(5);
		ev = 4'hF;
		wn(1);
		ev = 4'h0;
		cmd(OP_READ_CLEAR, STATUS_ONE_ADDR, 24'h000000);
		chk(rd, 24'h5E0000);
		rdc(STATUS_ONE_ADDR, 24'h400000);
		cmd(OP_WRITE, CONFIG_ADDR, 24'h800000);
		WAKE_PIN = 1'b0;
		wn(5);
		rdc(STATUS_ONE_ADDR, 24'h400000);
		chk(WAKE_MEASURE_MODE, 1);
		cmd(OP_WRITE, STATUS_ONE_ADDR, 24'hFFFFFF);
		rdc(STATUS_ONE_ADDR, 24'h400000);
		stop_test;
	end
	// Hang guard
	initial begin
		#100000;
		miscompares++;
		stop_test;
	end
endmodule
